// ==== core/adc_sequencer_timer_reload.sv ====
// converter sequencer and 16-bit reload timer behind an apb slave
// assumes one ref_clk; machine_ce marks machine cycles and freezes all state when low
//
// Behaviour
// (RULE1) The control register selects one of eight channels, single or continuous mode, and shows busy.
// (RULE2) The result register holds the 8-bit result until the next completed conversion replaces it.
// (RULE3) Software may read and write the result register as a general-purpose register.
// (RULE4) The reference program sets the internal references, and zero makes them the external ones.
// (RULE5) Every reference program write starts a new conversion, aborting any running one.
// (RULE6) The conversion sequence begins in the machine cycle after the start write.
// (RULE7) Busy is set in the same machine cycle as the reference program write.
// (RULE8) With a zero reference program a conversion takes 15 machine cycles.
// (RULE9) The channel is tracked for the first 5 cycles and then held for the rest.
// (RULE10) Approximation of the held level runs from the 6th to the 15th cycle; the code decides bits in cycles 6 to 13 only.
// (RULE11) The result moves into the result register in the 15th cycle.
// (RULE12) Two select bits choose no reload, reload on overflow, or reload on a trigger falling edge.
// (RULE13) On wrap from all ones the counter sets the overflow flag and loads the preset reload value.
// (RULE14) The reload happens in the overflow cycle so the zero count never shows.
// (RULE15) Busy clears at result transfer, and continuous mode restarts on the same channel.
// (RULE16) The counter counts once per machine cycle and software clears the overflow flag.
`timescale 1ns/1ns
`include "adc_timer_defs.svh"
module adc_sequencer_timer_reload
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic machine_ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_high,
  input wire logic reload_trigger_pin,
  output logic [2:0] channel_select,
  output logic sample_track,
  output logic [7:0] dac_trial,
  output logic [3:0] internal_upper_reference,
  output logic [3:0] internal_lower_reference,
  output logic use_external_reference,
  output logic [15:0] timer_count,
  output logic irq
);

  // ****************************************
  // helper functions
  // ****************************************
  function automatic adc_timer_pkg::reload_mode_t decode_mode(input logic [1:0] sel);
    adc_timer_pkg::reload_mode_t m;
    m = adc_timer_pkg::reload_off;
    if (sel[1])
      m = sel[0] ? adc_timer_pkg::reload_on_trigger : adc_timer_pkg::reload_on_overflow;
    return m;
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // ****************************************
  // apb access decode
  // ****************************************
  logic access;
  logic wr;
  logic mapped;

  assign pready = machine_ce;
  assign access = psel && penable && machine_ce;
  assign wr = access && pwrite;

  always_comb
  begin
    mapped = hit(paddr, `OFS_CONVERTER_CONTROL) || hit(paddr, `OFS_CONVERSION_RESULT)
             || hit(paddr, `OFS_REFERENCE_PROGRAM) || hit(paddr, `OFS_TIMER_CONTROL)
             || hit(paddr, `OFS_TIMER_COUNT) || hit(paddr, `OFS_TIMER_RELOAD)
             || hit(paddr, `OFS_IRQ_STATUS) || hit(paddr, `OFS_IRQ_MASK);
  end

  assign pslverr = psel && penable && !mapped;

  logic wr_control;
  logic wr_result;
  logic wr_refprog;
  logic wr_tcontrol;
  logic wr_count;
  logic wr_reload;
  logic wr_status;
  logic wr_mask;

  assign wr_control = wr && hit(paddr, `OFS_CONVERTER_CONTROL);
  assign wr_result = wr && hit(paddr, `OFS_CONVERSION_RESULT);
  assign wr_refprog = wr && hit(paddr, `OFS_REFERENCE_PROGRAM);
  assign wr_tcontrol = wr && hit(paddr, `OFS_TIMER_CONTROL);
  assign wr_count = wr && hit(paddr, `OFS_TIMER_COUNT);
  assign wr_reload = wr && hit(paddr, `OFS_TIMER_RELOAD);
  assign wr_status = wr && hit(paddr, `OFS_IRQ_STATUS);
  assign wr_mask = wr && hit(paddr, `OFS_IRQ_MASK);

  // ****************************************
  // converter registers
  // ****************************************
  logic continuous;
  logic busy;
  logic [7:0] result;
  logic [7:0] refprog;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      channel_select <= 3'h0;
      continuous <= 1'b0;
    end
    else if (machine_ce && wr_control)
    begin
      channel_select <= pwdata[`CTRL_CHANNEL_LSB +: 3]; // see RULE1
      continuous <= pwdata[`CTRL_CONTINUOUS_BIT]; // see RULE1
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      refprog <= `REFPROG_RESET;
    else if (machine_ce && wr_refprog)
      refprog <= pwdata[7:0];
  end

  // upper nibble programs the upper level, lower nibble the lower one
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      internal_upper_reference <= 4'h0;
      internal_lower_reference <= 4'h0;
      use_external_reference <= 1'b1;
    end
    else if (machine_ce)
    begin
      internal_upper_reference <= refprog[7:4]; // see RULE4
      internal_lower_reference <= refprog[3:0]; // see RULE4
      use_external_reference <= refprog == 8'h00; // see RULE4
    end
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  adc_timer_pkg::conv_phase_t phase;
  logic [3:0] cycle;
  logic finishing;
  logic restart;

  // cycle holds the number of the machine cycle now running, 1 to 15
  assign finishing = phase != adc_timer_pkg::phase_idle && cycle == `CONVERSION_CYCLES;
  assign restart = finishing && continuous && !wr_refprog;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      phase <= adc_timer_pkg::phase_idle;
      cycle <= 4'h0;
    end
    else if (machine_ce)
    begin
      if (wr_refprog || restart)
      begin
        // a start write always wins, aborting whatever runs
        phase <= adc_timer_pkg::phase_sample; // see RULE5, RULE6
        cycle <= 4'h1; // see RULE6
      end
      else
      begin
        unique case (phase)
          adc_timer_pkg::phase_idle:
            cycle <= 4'h0;
          adc_timer_pkg::phase_sample:
          begin
            cycle <= cycle + 4'h1;
            if (cycle == `SAMPLE_LAST_CYCLE)
              phase <= adc_timer_pkg::phase_approx; // see RULE9
          end
          adc_timer_pkg::phase_approx:
          begin
            cycle <= cycle + 4'h1;
            if (cycle == `APPROX_LAST_CYCLE)
              phase <= adc_timer_pkg::phase_finish; // see RULE10
          end
          adc_timer_pkg::phase_finish:
          begin
            cycle <= cycle + 4'h1;
            if (cycle == `CONVERSION_CYCLES)
            begin
              phase <= adc_timer_pkg::phase_idle; // see RULE8
              cycle <= 4'h0;
            end
          end
        endcase
      end
    end
  end

  // busy rises at the start write itself, not one cycle later
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      busy <= 1'b0;
    else if (machine_ce)
    begin
      if (wr_refprog)
        busy <= 1'b1; // see RULE7
      else if (finishing && !continuous)
        busy <= 1'b0; // see RULE15
    end
  end

  assign sample_track = phase == adc_timer_pkg::phase_sample; // see RULE9

  // bits decided in cycles 6 to 13; 14 and 15 leave the ladder settled
  sar_register sar
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .machine_ce(machine_ce),
    .clear(wr_refprog || restart || phase == adc_timer_pkg::phase_sample),
    .step(phase == adc_timer_pkg::phase_approx), // see RULE10
    .comparator_high(comparator_high),
    .trial_code(dac_trial)
  );

  // a transfer beats a software write landing in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      result <= `RESULT_RESET;
    else if (machine_ce)
    begin
      if (finishing)
        result <= dac_trial; // see RULE11, RULE2
      else if (wr_result)
        result <= pwdata[7:0]; // see RULE3
    end
  end

  // ****************************************
  // reload timer
  // ****************************************
  logic [1:0] reload_select;
  logic run;
  logic [15:0] reload_value;
  logic overflow_flag;
  logic trig_meta;
  logic trig_sync;
  logic trig_prev;
  logic trig_fall;
  logic wrap;
  adc_timer_pkg::reload_mode_t mode;

  assign mode = decode_mode(reload_select); // see RULE12

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      reload_select <= 2'h0;
      run <= 1'b0;
    end
    else if (machine_ce && wr_tcontrol)
    begin
      reload_select[0] <= pwdata[`TCTRL_SELECT_LOW_BIT];
      reload_select[1] <= pwdata[`TCTRL_SELECT_HIGH_BIT];
      run <= pwdata[`TCTRL_RUN_BIT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reload_value <= `RELOAD_RESET;
    else if (machine_ce && wr_reload)
      reload_value <= pwdata[15:0];
  end

  // pin passes two flops before the edge detector sees it
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      trig_meta <= 1'b1;
      trig_sync <= 1'b1;
      trig_prev <= 1'b1;
    end
    else if (machine_ce)
    begin
      trig_meta <= reload_trigger_pin;
      trig_sync <= trig_meta;
      trig_prev <= trig_sync;
    end
  end

  assign trig_fall = trig_prev && !trig_sync;
  assign wrap = run && timer_count == `COUNT_ALL_ONES;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      timer_count <= 16'h0000;
    else if (machine_ce)
    begin
      if (wr_count)
        timer_count <= pwdata[15:0];
      else if (mode == adc_timer_pkg::reload_on_trigger && trig_fall)
        timer_count <= reload_value; // see RULE12
      else if (wrap && mode == adc_timer_pkg::reload_on_overflow)
        timer_count <= reload_value; // see RULE13, RULE14
      else if (run)
        timer_count <= timer_count + 16'h0001; // see RULE16
    end
  end

  // ****************************************
  // interrupt status and mask
  // ****************************************
  logic [2:0] status;
  logic [2:0] mask;
  logic [2:0] events;

  assign events = {mode == adc_timer_pkg::reload_on_trigger && trig_fall, wrap, finishing};
  assign overflow_flag = status[`IRQ_OVERFLOW_BIT]; // see RULE13

  // a new event in the clearing cycle keeps its bit set
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      status <= 3'h0;
    else if (machine_ce)
      status <= (status & ~(wr_status ? pwdata[2:0] : 3'h0)) | events; // see RULE16
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      mask <= 3'h0;
    else if (machine_ce && wr_mask)
      mask <= pwdata[2:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      irq <= 1'b0;
    else if (machine_ce)
      irq <= |(((status & ~(wr_status ? pwdata[2:0] : 3'h0)) | events) & mask);
  end

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] next_prdata;

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (hit(paddr, `OFS_CONVERTER_CONTROL))
    begin
      next_prdata[`CTRL_CHANNEL_LSB +: 3] = channel_select;
      next_prdata[`CTRL_CONTINUOUS_BIT] = continuous;
      next_prdata[`CTRL_BUSY_BIT] = busy; // see RULE1
    end
    else if (hit(paddr, `OFS_CONVERSION_RESULT))
      next_prdata[7:0] = result; // see RULE3
    else if (hit(paddr, `OFS_REFERENCE_PROGRAM))
      next_prdata[7:0] = refprog;
    else if (hit(paddr, `OFS_TIMER_CONTROL))
    begin
      next_prdata[`TCTRL_SELECT_LOW_BIT] = reload_select[0];
      next_prdata[`TCTRL_SELECT_HIGH_BIT] = reload_select[1];
      next_prdata[`TCTRL_RUN_BIT] = run;
      next_prdata[`TCTRL_OVERFLOW_BIT] = overflow_flag;
    end
    else if (hit(paddr, `OFS_TIMER_COUNT))
      next_prdata[15:0] = timer_count;
    else if (hit(paddr, `OFS_TIMER_RELOAD))
      next_prdata[15:0] = reload_value;
    else if (hit(paddr, `OFS_IRQ_STATUS))
      next_prdata[2:0] = status;
    else if (hit(paddr, `OFS_IRQ_MASK))
      next_prdata[2:0] = mask;
  end

  // registered in the setup cycle so the access phase sees stable data
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      prdata <= 32'h0000_0000;
    else if (machine_ce && psel && !penable)
      prdata <= next_prdata;
  end

endmodule

// ==== core/sar_register.sv ====
// successive-approximation code register, one bit decided per enabled step
// assumes comparator_high is a combinational output of the analog macro, valid in the same ref_clk cycle as trial_code
`timescale 1ns/1ns
module sar_register
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic machine_ce,
  input wire logic clear,
  input wire logic step,
  input wire logic comparator_high,
  output logic [7:0] trial_code
);

  logic [7:0] code;
  logic [7:0] test_bit;

  // test bit walks from msb to lsb; zero once all eight are decided
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      code <= 8'h00;
      test_bit <= 8'h80;
    end
    else if (machine_ce)
    begin
      if (clear)
      begin
        code <= 8'h00;
        test_bit <= 8'h80;
      end
      else if (step && test_bit != 8'h00)
      begin
        // keep the bit while the held level is at or above the trial
        if (comparator_high)
          code <= code | test_bit;
        test_bit <= test_bit >> 1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      trial_code <= 8'h00;
    else if (machine_ce)
      trial_code <= clear ? 8'h80 : ((step && comparator_high) ? (code | test_bit) : code)
                    | (step ? (test_bit >> 1) : test_bit);
  end

endmodule

// ==== pkg/adc_timer_defs.svh ====
// offsets, field positions, reset values and cycle counts for the converter and reload timer
// assumes inclusion by bare name from files of the core
`ifndef ADC_TIMER_DEFS_SVH
`define ADC_TIMER_DEFS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_CONVERTER_CONTROL 8'h00
`define OFS_CONVERSION_RESULT 8'h04
`define OFS_REFERENCE_PROGRAM 8'h08
`define OFS_TIMER_CONTROL 8'h0C
`define OFS_TIMER_COUNT 8'h10
`define OFS_TIMER_RELOAD 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_MASK 8'h1C

// ****************************************
// field positions
// ****************************************
`define CTRL_CHANNEL_LSB 0
`define CTRL_CONTINUOUS_BIT 3
`define CTRL_BUSY_BIT 4
`define TCTRL_SELECT_LOW_BIT 0
`define TCTRL_SELECT_HIGH_BIT 1
`define TCTRL_RUN_BIT 2
`define TCTRL_OVERFLOW_BIT 7
`define IRQ_CONV_DONE_BIT 0
`define IRQ_OVERFLOW_BIT 1
`define IRQ_TRIGGER_BIT 2

// ****************************************
// reset values and counts
// ****************************************
`define RESULT_RESET 8'h00
`define REFPROG_RESET 8'h00
`define RELOAD_RESET 16'h0000
`define COUNT_ALL_ONES 16'hFFFF
`define SAMPLE_LAST_CYCLE 4'h5
`define APPROX_LAST_CYCLE 4'hD
`define CONVERSION_CYCLES 4'hF

`endif

// ==== pkg/adc_timer_pkg.sv ====
// types shared by the converter sequencer and the reload timer
// assumes the defines header supplies all numeric constants
package adc_timer_pkg;

  typedef enum logic [1:0] {
    phase_idle,
    phase_sample,
    phase_approx,
    phase_finish
  } conv_phase_t;

  typedef enum logic [1:0] {
    reload_off,
    reload_on_overflow,
    reload_on_trigger
  } reload_mode_t;

endpackage

// ==== tb/adc_sequencer_timer_reload_assertions.sv ====
// port checker for the converter sequencer and reload timer
// assumes machine_ce stays high during checked sequences; bound to the top module
`timescale 1ns/1ns
`include "adc_timer_defs.svh"
module adc_sequencer_timer_reload_checker
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic machine_ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] channel_select,
  input wire logic sample_track,
  input wire logic [3:0] internal_upper_reference,
  input wire logic [3:0] internal_lower_reference,
  input wire logic use_external_reference,
  input wire logic [15:0] timer_count
);
  logic [1:0] mode;
  logic run;
  logic [15:0] reload;
  logic [3:0] since;
  wire acc_wr = psel && penable && pwrite && machine_ce;
  wire start = acc_wr && paddr == `OFS_REFERENCE_PROGRAM;
  wire tick = run && machine_ce && !acc_wr;

  // ****************************************
  // shadows of software state
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mode <= 2'h0;
      run <= 1'b0;
    end
    else if (acc_wr && paddr == `OFS_TIMER_CONTROL)
    begin
      mode <= pwdata[1:0];
      run <= pwdata[`TCTRL_RUN_BIT];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reload <= `RELOAD_RESET;
    else if (acc_wr && paddr == `OFS_TIMER_RELOAD)
      reload <= pwdata[15:0];
  end

  // saturates at F so a restart in continuous mode is not checked
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      since <= 4'hF;
    else if (start)
      since <= 4'h1;
    else if (since != 4'hF && machine_ce)
      since <= since + 4'h1;
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_start;
    start;
  endsequence

  sequence s_track;
    sample_track[*5];
  endsequence

  AST_SAMPLE:
    assert property (s_start |=> s_track) else $error("tracking not five cycles");
  AST_APPROX:
    assert property (since >= 4'h6 && since <= 4'hD |-> !sample_track)
      else $error("tracking during approximation");
  AST_REFS:
    // levels follow the stored program one cycle after it lands
    assert property (s_start |-> ##2 internal_upper_reference == $past(pwdata[7:4], 2)
      && internal_lower_reference == $past(pwdata[3:0], 2)
      && use_external_reference == ($past(pwdata[7:0], 2) == 8'h00))
      else $error("reference levels wrong");
  AST_CHANNEL:
    assert property (acc_wr && paddr == `OFS_CONVERTER_CONTROL |=>
      channel_select == $past(pwdata[2:0])) else $error("channel not selected");
  AST_STEP:
    assert property (tick && mode != 2'h3 && timer_count != 16'hFFFF |=>
      timer_count == $past(timer_count) + 16'h1) else $error("count step wrong");
  AST_RELOAD:
    assert property (tick && mode == 2'h2 && timer_count == 16'hFFFF |=> timer_count == reload)
      else $error("no reload on overflow");
  AST_NO_ZERO:
    assert property (tick && mode == 2'h2 && timer_count == 16'hFFFF |=> timer_count != 16'h0)
      else $error("zero count shown");
  AST_WRAP:
    assert property (tick && !mode[1] && timer_count == 16'hFFFF |=> timer_count == 16'h0)
      else $error("reload while disabled");
endmodule

bind adc_sequencer_timer_reload adc_sequencer_timer_reload_checker u_chk (.ref_clk(ref_clk),
  .reset(reset), .machine_ce(machine_ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .channel_select(channel_select), .sample_track(sample_track),
  .internal_upper_reference(internal_upper_reference),
  .internal_lower_reference(internal_lower_reference),
  .use_external_reference(use_external_reference), .timer_count(timer_count));

// ==== tb/adc_sequencer_timer_reload_tb.sv ====
// self-checking bench for the converter sequencer and reload timer
// assumes the analog source model on the comparator side
`timescale 1ns/1ns
`include "adc_timer_defs.svh"
module adc_sequencer_timer_reload_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic machine_ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic pready, pslverr, comparator_high, sample_track, irq, sl_err, ext_ref;
  logic [2:0] channel_select;
  logic [7:0] dac_trial, prev;
  logic [3:0] up_ref, lo_ref;
  logic [15:0] timer_count;
  logic [63:0] levels = 64'h5A3CC3017F80FF00;
  int err_count = 0;
  int n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  adc_sequencer_timer_reload DUT (.ref_clk(ref_clk), .reset(reset), .machine_ce(machine_ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparator_high(comparator_high),
    .reload_trigger_pin(trig), .channel_select(channel_select), .sample_track(sample_track),
    .dac_trial(dac_trial), .internal_upper_reference(up_ref), .internal_lower_reference(lo_ref),
    .use_external_reference(ext_ref), .timer_count(timer_count), .irq(irq));

  analog_source_model src (.ref_clk(ref_clk), .reset(reset), .levels(levels),
    .channel_select(channel_select), .sample_track(sample_track), .dac_trial(dac_trial),
    .comparator_high(comparator_high));

  // ****************************************
  // access and compare tasks
  // ****************************************
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd_data = prdata;
    sl_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      err_count++;
      conclude();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(rd_data, exp);
  endtask

  task automatic wait_ffff;
    int n;
    n = 0;
    while (timer_count !== 16'hFFFF && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n >= 200)
    begin
      err_count++;
      conclude();
    end
    @(negedge ref_clk);
  endtask

  task automatic convert(input logic [2:0] ch, input logic [7:0] old);
    wr(`OFS_CONVERTER_CONTROL, {29'h0, ch});
    wr(`OFS_REFERENCE_PROGRAM, 32'h0);
    rdc(`OFS_CONVERTER_CONTROL, {28'h1, 1'b0, ch});
    repeat (4) @(posedge ref_clk);
    rdc(`OFS_CONVERSION_RESULT, {24'h0, old});
    repeat (10) @(posedge ref_clk);
    rdc(`OFS_CONVERTER_CONTROL, {29'h0, ch});
    rdc(`OFS_CONVERSION_RESULT, {24'h0, levels[ch * 8 +: 8]});
    rdc(`OFS_IRQ_STATUS, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h1);
    rdc(`OFS_IRQ_STATUS, 32'h0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(`OFS_CONVERTER_CONTROL, 32'h0);
    rdc(`OFS_CONVERSION_RESULT, 32'h0);
    rdc(`OFS_REFERENCE_PROGRAM, 32'h0);
    check({31'h0, ext_ref}, 32'h1);
    apb(8'h20, 1'b0, 32'h0);
    check({rd_data[30:0], sl_err}, 32'h1);
    wr(`OFS_CONVERSION_RESULT, 32'hA5);
    rdc(`OFS_CONVERSION_RESULT, 32'hA5);
    prev = 8'hA5;
    for (int i = 0; i < 8; i++)
    begin
      convert(i[2:0], prev);
      prev = levels[i * 8 +: 8];
    end
    wr(`OFS_REFERENCE_PROGRAM, 32'h5A);
    repeat (20) @(posedge ref_clk);
    check({23'h0, ext_ref, up_ref, lo_ref}, 32'h5A);
    wr(`OFS_IRQ_MASK, 32'h1);
    wr(`OFS_REFERENCE_PROGRAM, 32'h0);
    repeat (20) @(posedge ref_clk);
    check({23'h0, ext_ref, up_ref, lo_ref}, 32'h100);
    check({31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    // abort: the second start must win over the first
    wr(`OFS_CONVERTER_CONTROL, 32'h1);
    wr(`OFS_REFERENCE_PROGRAM, 32'h0);
    repeat (8) @(posedge ref_clk);
    levels[15:8] <= 8'h9C;
    wr(`OFS_REFERENCE_PROGRAM, 32'h0);
    // read after the aborted run would have ended, so a missed abort shows
    repeat (6) @(posedge ref_clk);
    rdc(`OFS_CONVERSION_RESULT, 32'h5A);
    repeat (20) @(posedge ref_clk);
    rdc(`OFS_CONVERSION_RESULT, 32'h9C);
    wr(`OFS_CONVERTER_CONTROL, 32'hA);
    wr(`OFS_REFERENCE_PROGRAM, 32'h0);
    repeat (40) @(posedge ref_clk);
    rdc(`OFS_CONVERTER_CONTROL, 32'h1A);
    levels[23:16] <= 8'h44;
    repeat (40) @(posedge ref_clk);
    rdc(`OFS_CONVERSION_RESULT, 32'h44);
    wr(`OFS_CONVERTER_CONTROL, 32'h2);
    repeat (40) @(posedge ref_clk);
    rdc(`OFS_CONVERTER_CONTROL, 32'h2);
    wr(`OFS_IRQ_STATUS, 32'h7);
    wr(`OFS_IRQ_MASK, 32'h2);
    wr(`OFS_TIMER_RELOAD, 32'h1234);
    wr(`OFS_TIMER_COUNT, 32'hFFF0);
    wr(`OFS_TIMER_CONTROL, 32'h6);
    wait_ffff();
    check({16'h0, timer_count}, 32'h1234);
    rdc(`OFS_IRQ_STATUS, 32'h2);
    rdc(`OFS_TIMER_CONTROL, 32'h86);
    check({31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h2);
    rdc(`OFS_IRQ_STATUS, 32'h0);
    wr(`OFS_TIMER_CONTROL, 32'h0);
    wr(`OFS_TIMER_COUNT, 32'hFFF8);
    wr(`OFS_TIMER_CONTROL, 32'h4);
    wait_ffff();
    check({16'h0, timer_count}, 32'h0);
    wr(`OFS_TIMER_CONTROL, 32'h0);
    wr(`OFS_TIMER_COUNT, 32'h8000);
    wr(`OFS_IRQ_STATUS, 32'h7);
    wr(`OFS_TIMER_CONTROL, 32'h7);
    trig <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rdc(`OFS_IRQ_STATUS, 32'h4);
    check({31'h0, timer_count >= 16'h1234 && timer_count < 16'h1240}, 32'h1);
    // enable low must freeze the running counter
    @(posedge ref_clk);
    machine_ce <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rd_data = {16'h0, timer_count};
    repeat (6) @(posedge ref_clk);
    check({16'h0, timer_count}, rd_data);
    machine_ce <= 1'b1;
    wr(`OFS_TIMER_CONTROL, 32'h0);
    conclude();
  end
endmodule

// ==== tb/analog_source_model.sv ====
// eight analog sources behind the multiplexer with sample-and-hold and comparator
// assumes levels holds channel n in bits 8n+7..8n
`timescale 1ns/1ns
module analog_source_model
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [63:0] levels,
  input wire logic [2:0] channel_select,
  input wire logic sample_track,
  input wire logic [7:0] dac_trial,
  output logic comparator_high
);
  logic [7:0] held;

  // capacitor follows the input only while tracking, later changes are ignored
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      held <= 8'h00;
    else if (sample_track)
      held <= levels[channel_select * 8 +: 8];
  end

  assign comparator_high = held >= dac_trial;
endmodule
